// File: rtl/io_regop_decoder.sv
// Decoder for I/O and register read/write instructions with an APB register port
`include "io_regop_cfg.svh"
`timescale 1ns/1ps
module io_regop_decoder (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Table entry fetch port, same clock
  output logic table_req_o,
  output logic [31:0] table_addr_o,
  input wire logic table_ack_i,
  input wire logic [31:0] table_data_i,
  // Selection results from the bus controller, same clock
  input wire logic sel_done_i,
  input wire logic sel_fail_i,
  // Decoded outputs
  output logic select_start_o,
  output logic [2:0] dest_id_o,
  output logic [7:0] sync_xfer_o,
  output logic [7:0] config_bits_o,
  output logic [31:0] next_ip_o,
  output logic [31:0] next_address_o,
  output logic target_role_o,
  output logic illegal_o,
  output logic acknowledge_out_o,
  output logic attention_out_o
);

  // ===========================================================
  // State registers
  io_regop_pkg::state_t s_q; // Registered state
  io_regop_pkg::state_t s_d; // Next state

  // ===========================================================
  // Instruction fields
  logic [2:0] opcode; // Opcode field
  logic is_io; // I/O class
  logic [6:0] reg_addr; // Target register address
  logic [7:0] imm_byte; // Immediate byte
  logic [7:0] alu_operand; // Chosen operand
  logic [31:0] rel_target; // Pointer plus signed offset
  logic [31:0] tbl_addr; // Table entry address
  io_regop_pkg::alu_res_t alu_res; // Arithmetic result

  // APB decode
  logic apb_access; // Access phase
  logic apb_first; // First access cycle, the answer is registered here
  logic apb_wr; // Write at the edge that completes the access
  logic regfile_hit; // Address in register window
  logic [6:0] rf_index; // Register window index

  assign opcode = s_q.first[`OPC_HI:`OPC_LO];
  assign is_io = (opcode <= `OPC_LAST_IO);
  assign reg_addr = s_q.first[`RADDR_HI:`RADDR_LO];
  assign imm_byte = s_q.first[`IMM_HI:`IMM_LO];
  assign alu_operand = (opcode == `OPC_MOVE_FROM) ? s_q.compare : s_q.regs[reg_addr];
  assign rel_target = s_q.instr_ptr + {{8{s_q.second[23]}}, s_q.second[23:0]};
  assign tbl_addr = s_q.data_base + {{8{s_q.first[`OFFSET_HI]}}, s_q.first[`OFFSET_HI:0]};

  assign apb_access = psel_i & penable_i;
  assign apb_first = apb_access & !s_q.pready;
  assign apb_wr = apb_access & pwrite_i & s_q.pready;
  assign regfile_hit = (paddr_i[11:9] == 3'(`OFS_REGFILE_BASE >> 9));
  assign rf_index = paddr_i[8:2];

  // ===========================================================
  // Arithmetic unit
  // operator field selects operation
  regop_alu u_alu (
    .op_i(io_regop_pkg::alu_op_t'(s_q.first[`OPER_HI:`OPER_LO])),
    .operand_i(alu_operand),
    .imm_i(imm_byte),
    .carry_i(s_q.carry),
    .res_o(alu_res)
  );

  // ===========================================================
  // Next-state logic: APB access, decode, table fetch, selection
  always_comb begin
    s_d = s_q;
    s_d.select_start = 1'b0;
    s_d.prdata = `RESET_WORD;
    s_d.pslverr = 1'b0;
    s_d.pready = 1'b0;

    // First access cycle: answer and error are registered together with ready
    if (apb_first) begin
      s_d.pready = 1'b1;
      if (regfile_hit) begin
        s_d.prdata = {24'h000000, s_q.regs[rf_index]};
      end else begin
        unique case (paddr_i)
          `OFS_INSTR_FIRST: s_d.prdata = s_q.first;
          `OFS_INSTR_SECOND: s_d.prdata = s_q.second;
          `OFS_CONTROL: s_d.prdata = {30'h0000_0000, s_q.loopback, 1'b0};
          `OFS_STATUS: begin
            s_d.prdata = {25'h000_0000, s_q.select_active, s_q.atn_latch,
                          s_q.ack_latch, s_q.target_role, s_q.carry,
                          s_q.illegal, (s_q.state != io_regop_pkg::ST_IDLE)};
          end
          `OFS_DATA_BASE: s_d.prdata = s_q.data_base;
          `OFS_INSTR_PTR: s_d.prdata = s_q.instr_ptr;
          `OFS_COMPARE: s_d.prdata = {24'h000000, s_q.compare};
          // Read-only words refuse a write
          `OFS_TABLE_ENTRY: begin
            s_d.prdata = s_q.table_entry;
            s_d.pslverr = pwrite_i;
          end
          `OFS_NEXT_ADDR: begin
            s_d.prdata = s_q.next_addr;
            s_d.pslverr = pwrite_i;
          end
          // Unmapped address answers with an error
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    // Register writes; the illegal status bit is cleared by writing one
    if (apb_wr) begin
      if (regfile_hit) begin
        s_d.regs[rf_index] = pwdata_i[7:0];
      end else begin
        unique case (paddr_i)
          `OFS_INSTR_FIRST: s_d.first = pwdata_i;
          `OFS_INSTR_SECOND: s_d.second = pwdata_i;
          `OFS_CONTROL: begin
            s_d.loopback = pwdata_i[`CTRL_LOOPBACK_BIT];
            // A start while busy is ignored, the running one finishes first
            if (pwdata_i[`CTRL_GO_BIT] && s_q.state == io_regop_pkg::ST_IDLE) begin
              s_d.state = io_regop_pkg::ST_FINISH;
            end
          end
          `OFS_STATUS: begin
            if (pwdata_i[`STAT_ILLEGAL_BIT]) begin
              s_d.illegal = 1'b0;
            end
          end
          `OFS_DATA_BASE: s_d.data_base = pwdata_i;
          `OFS_INSTR_PTR: s_d.instr_ptr = pwdata_i;
          `OFS_COMPARE: s_d.compare = pwdata_i[7:0];
          // Read-only or unmapped: write dropped, error raised with ready
          default: begin
          end
        endcase
      end
    end

    // Start of execution: selection-type opcodes in table mode go fetch their entry first
    if (s_d.state == io_regop_pkg::ST_FINISH && s_q.state == io_regop_pkg::ST_IDLE) begin
      if (is_io && s_q.first[`MODE_TABLE_BIT] && opcode < `OPC_SET) begin
        s_d.state = io_regop_pkg::ST_TABLE;
        s_d.table_addr = tbl_addr;
        s_d.table_req = 1'b1;
      end
    end

    unique case (s_q.state)
      io_regop_pkg::ST_IDLE: begin
      end
      // Wait for the four-byte table entry
      io_regop_pkg::ST_TABLE: begin
        if (table_ack_i) begin
          s_d.table_entry = table_data_i;
          s_d.config_bits = table_data_i[7:0];
          s_d.dest_id = table_data_i[10:8];
          s_d.sync_xfer = table_data_i[23:16];
          s_d.table_req = 1'b0;
          s_d.state = io_regop_pkg::ST_FINISH;
        end
      end
      // Execute the decoded instruction
      io_regop_pkg::ST_FINISH: begin
        s_d.state = io_regop_pkg::ST_IDLE;
        s_d.next_addr = s_q.second;
        s_d.instr_ptr = s_q.instr_ptr + `INSTR_BYTES;
        if (is_io) begin
          // low bits 2-0 looked at only as part of the table offset
          if (!s_q.first[`MODE_TABLE_BIT]) begin
            s_d.dest_id = s_q.first[`ID_HI:`ID_LO];
          end
          if (s_q.first[`MODE_REL_BIT]) begin
            s_d.alt_target = rel_target;
          end else begin
            s_d.alt_target = s_q.second;
          end
          if (s_q.first[`SEL_ATN_BIT] && opcode != `OPC_SELECT) begin
            s_d.illegal = 1'b1;
          end else if (opcode < `OPC_SET) begin
            // Selection-type instruction goes to the bus controller
            s_d.select_start = 1'b1;
            s_d.select_active = 1'b1;
            s_d.sel_attn = (opcode == `OPC_SELECT) && s_q.first[`SEL_ATN_BIT];
          end else if (opcode == `OPC_SET || opcode == `OPC_CLEAR) begin
            if (s_q.first[`CARRY_BIT]) begin
              s_d.carry = (opcode == `OPC_SET);
            end
            if (s_q.first[`TARGET_BIT]) begin
              s_d.target_role = (opcode == `OPC_SET);
            end
            if (s_q.first[`ACK_BIT]) begin
              s_d.ack_latch = (opcode == `OPC_SET);
            end
            if (s_q.first[`ATN_BIT]) begin
              s_d.atn_latch = (opcode == `OPC_SET);
            end
          end
        end else begin
          if (s_q.first[`OPER_HI:`OPER_LO] == io_regop_pkg::OP_SHL ||
              s_q.first[`OPER_HI:`OPER_LO] == io_regop_pkg::OP_SHR ||
              s_q.first[`OPER_HI] && s_q.first[`OPER_HI - 1]) begin
            s_d.carry = alu_res.carry;
          end
          if (opcode == `OPC_MOVE_TO) begin
            s_d.compare = alu_res.result;
          end else begin
            s_d.regs[reg_addr] = alu_res.result;
          end
        end
      end
      default: begin
        s_d.state = io_regop_pkg::ST_IDLE;
      end
    endcase

    // Selection outcome from the bus controller
    if (s_q.select_active && sel_fail_i) begin
      s_d.instr_ptr = s_q.alt_target;
      s_d.select_active = 1'b0;
      s_d.sel_attn = 1'b0;
    end else if (s_q.select_active && sel_done_i) begin
      s_d.select_active = 1'b0;
      s_d.sel_attn = 1'b0;
    end

    // Illegal flag: a new event wins over a same-cycle clear
    if (s_q.state == io_regop_pkg::ST_FINISH && is_io && s_q.first[`SEL_ATN_BIT] &&
        opcode != `OPC_SELECT) begin
      s_d.illegal = 1'b1;
    end

    // drive only as initiator or loopback
    s_d.ack_out = s_d.ack_latch && (!s_d.target_role || s_d.loopback);
    s_d.atn_out = (s_d.atn_latch || s_d.sel_attn) && (!s_d.target_role || s_d.loopback);
  end

  // ===========================================================
  // State register with synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.state <= io_regop_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // Outputs straight from flip-flops
  assign prdata_o = s_q.prdata;
  // One wait state: ready rises with the registered answer, so the master
  // takes read data and error at the same edge that completes the access
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign table_req_o = s_q.table_req;
  assign table_addr_o = s_q.table_addr;
  assign select_start_o = s_q.select_start;
  assign dest_id_o = s_q.dest_id;
  assign sync_xfer_o = s_q.sync_xfer;
  assign config_bits_o = s_q.config_bits;
  assign next_ip_o = s_q.instr_ptr;
  assign next_address_o = s_q.next_addr;
  assign target_role_o = s_q.target_role;
  assign illegal_o = s_q.illegal;
  assign acknowledge_out_o = s_q.ack_out;
  assign attention_out_o = s_q.atn_out;

endmodule

// File: rtl/io_regop_cfg.svh
// Offsets, field positions, reset values and pointer step for the instruction decoder
`ifndef IO_REGOP_CFG_SVH
`define IO_REGOP_CFG_SVH

// ===========================================================
// Register byte offsets on the APB
`define OFS_INSTR_FIRST 12'h000
`define OFS_INSTR_SECOND 12'h004
`define OFS_CONTROL 12'h008
`define OFS_STATUS 12'h00C
`define OFS_DATA_BASE 12'h010
`define OFS_INSTR_PTR 12'h014
`define OFS_COMPARE 12'h018
`define OFS_TABLE_ENTRY 12'h01C
`define OFS_NEXT_ADDR 12'h020
`define OFS_REGFILE_BASE 12'h200

// ===========================================================
// Instruction field positions
`define OPC_HI 29
`define OPC_LO 27
`define OPER_HI 26
`define OPER_LO 24
`define MODE_REL_BIT 26
`define MODE_TABLE_BIT 25
`define SEL_ATN_BIT 24
`define OFFSET_HI 23
`define ID_HI 18
`define ID_LO 16
`define RADDR_HI 22
`define RADDR_LO 16
`define IMM_HI 15
`define IMM_LO 8
`define CARRY_BIT 10
`define TARGET_BIT 9
`define ACK_BIT 6
`define ATN_BIT 3

// ===========================================================
// Opcode values
`define OPC_SELECT 3'h0
`define OPC_SET 3'h3
`define OPC_CLEAR 3'h4
`define OPC_LAST_IO 3'h4
`define OPC_MOVE_FROM 3'h5
`define OPC_MOVE_TO 3'h6
`define OPC_RMW 3'h7

// ===========================================================
// Control and status bit positions
`define CTRL_GO_BIT 0
`define CTRL_LOOPBACK_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_ILLEGAL_BIT 1
`define STAT_CARRY_BIT 2
`define STAT_TARGET_BIT 3
`define STAT_ACK_BIT 4
`define STAT_ATN_BIT 5
`define STAT_SELECT_BIT 6

// ===========================================================
// Reset values and step of the instruction pointer
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000
`define INSTR_BYTES 32'h0000_0008

`endif

// File: rtl/io_regop_pkg.sv
// Types shared by the instruction decoder and its arithmetic unit
package io_regop_pkg;

  // ===========================================================
  // Operator codes of a read/write instruction
  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_SHL = 3'h1,
    OP_OR = 3'h2,
    OP_XOR = 3'h3,
    OP_AND = 3'h4,
    OP_SHR = 3'h5,
    OP_ADD = 3'h6,
    OP_ADDC = 3'h7
  } alu_op_t;

  // ===========================================================
  // Sequencer states, Gray along idle -> table wait -> finish
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TABLE = 2'h1,
    ST_FINISH = 2'h3
  } seq_state_t;

  // ===========================================================
  // Result of one pass through the arithmetic unit
  typedef struct packed {
    logic [7:0] result;
    logic carry;
  } alu_res_t;

  // ===========================================================
  // Whole state of the decoder
  typedef struct packed {
    seq_state_t state;
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] data_base;
    logic [31:0] instr_ptr;
    logic [31:0] alt_target;
    logic [31:0] next_addr;
    logic [31:0] table_entry;
    logic [31:0] table_addr;
    logic table_req;
    logic [7:0] compare;
    logic carry;
    logic target_role;
    logic ack_latch;
    logic atn_latch;
    logic loopback;
    logic illegal;
    logic select_active;
    logic sel_attn;
    logic select_start;
    logic [2:0] dest_id;
    logic [7:0] sync_xfer;
    logic [7:0] config_bits;
    logic ack_out;
    logic atn_out;
    logic [127:0][7:0] regs;
    logic [31:0] prdata;
    logic pslverr;
    logic pready;
  } state_t;

endpackage

// File: rtl/regop_alu.sv
// Eight-operator byte arithmetic unit with carry
`timescale 1ns/1ps
module regop_alu (
  input wire io_regop_pkg::alu_op_t op_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] imm_i,
  input wire logic carry_i,
  output io_regop_pkg::alu_res_t res_o
);

  // ===========================================================
  // Operation select
  // operator code decode
  always_comb begin
    logic [8:0] sum;
    sum = 9'h000;
    res_o.result = operand_i;
    res_o.carry = carry_i;
    unique case (op_i)
      io_regop_pkg::OP_LOAD: begin
        res_o.result = imm_i;
      end
      io_regop_pkg::OP_SHL: begin
        res_o.result = {operand_i[6:0], carry_i};
        res_o.carry = operand_i[7];
      end
      io_regop_pkg::OP_SHR: begin
        res_o.result = {carry_i, operand_i[7:1]};
        res_o.carry = operand_i[0];
      end
      io_regop_pkg::OP_OR: begin
        res_o.result = operand_i | imm_i;
      end
      io_regop_pkg::OP_XOR: begin
        res_o.result = operand_i ^ imm_i;
      end
      io_regop_pkg::OP_AND: begin
        res_o.result = operand_i & imm_i;
      end
      io_regop_pkg::OP_ADD: begin
        sum = {1'b0, operand_i} + {1'b0, imm_i};
        res_o.result = sum[7:0];
        res_o.carry = sum[8];
      end
      io_regop_pkg::OP_ADDC: begin
        sum = {1'b0, operand_i} + {1'b0, imm_i} + {8'h00, carry_i};
        res_o.result = sum[7:0];
        res_o.carry = sum[8];
      end
    endcase
  end

endmodule

// File: bench/io_regop_props.sv
// Port-level checks for the instruction decoder
`timescale 1ns/1ps
module io_regop_props (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic table_req_o,
  input wire logic [31:0] table_addr_o,
  input wire logic table_ack_i,
  input wire logic [31:0] table_data_i,
  input wire logic select_start_o,
  input wire logic [2:0] dest_id_o,
  input wire logic [7:0] sync_xfer_o,
  input wire logic [31:0] next_address_o,
  input wire logic target_role_o,
  input wire logic illegal_o,
  input wire logic acknowledge_out_o,
  input wire logic attention_out_o
);
  // ===========================================================
  // Helper state
  logic lb_q;
  logic [2:0] id_q;
  logic [7:0] sy_q;
  wire acc = psel_i && penable_i;
  wire w1c = acc && pwrite_i && paddr_i == 12'h00C && pwdata_i[1];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // Mirror loopback and the fetched entry, since they are not on the ports
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lb_q <= 1'b0;
      id_q <= 3'h0;
      sy_q <= 8'h00;
    end else begin
      if (acc && pready_o && pwrite_i && paddr_i == 12'h008) begin
        lb_q <= pwdata_i[1];
      end
      if (table_ack_i && table_req_o) begin
        id_q <= table_data_i[10:8];
        sy_q <= table_data_i[23:16];
      end
    end
  end
  // ===========================================================
  // Properties
  property p_tab_hold;
    table_req_o && $past(table_req_o) |-> $stable(table_addr_o);
  endproperty
  a_tab_hold: assert property (p_tab_hold) else $error("table address moved");
  property p_req_drop;
    table_req_o && table_ack_i |=> !table_req_o;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("table request held");
  sequence s_fields;
    ##[1:2] (dest_id_o == id_q && sync_xfer_o == sy_q);
  endsequence
  property p_fields;
    table_req_o && table_ack_i |-> s_fields;
  endproperty
  a_fields: assert property (p_fields) else $error("table fields not loaded");
  property p_sel_pulse;
    select_start_o |=> !select_start_o;
  endproperty
  a_sel_pulse: assert property (p_sel_pulse) else $error("select start too long");
  // A target-role device with loopback off keeps both lines quiet
  property p_gate;
    target_role_o && $past(target_role_o) && !lb_q && !$past(lb_q)
      |-> !acknowledge_out_o && !attention_out_o;
  endproperty
  a_gate: assert property (p_gate) else $error("ack or attention in target role");
  property p_illegal;
    $fell(illegal_o) |-> $past(w1c) || $past(w1c, 2);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal flag lost");
  property p_err;
    acc && !pready_o && paddr_i >= 12'h024 && paddr_i < 12'h200 |=> pslverr_o && pready_o;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_rdback;
    acc && !pready_o && !pwrite_i && paddr_i == 12'h020 |=> prdata_o == $past(next_address_o);
  endproperty
  a_rdback: assert property (p_rdback) else $error("next address readback wrong");
endmodule

bind io_regop_decoder io_regop_props u_props (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o), .table_req_o(table_req_o), .table_addr_o(table_addr_o),
  .table_ack_i(table_ack_i), .table_data_i(table_data_i), .select_start_o(select_start_o),
  .dest_id_o(dest_id_o), .sync_xfer_o(sync_xfer_o), .next_address_o(next_address_o),
  .target_role_o(target_role_o), .illegal_o(illegal_o),
  .acknowledge_out_o(acknowledge_out_o), .attention_out_o(attention_out_o));

// File: bench/scsi_side_model.sv
// Far-side model: table memory and the selected bus device
`timescale 1ns/1ps
module scsi_side_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic table_req_i,
  input wire logic [31:0] table_addr_i,
  input wire logic select_i,
  input wire logic fail_i,
  input wire logic [4:0] dly_i,
  output logic table_ack_o,
  output logic [31:0] table_data_o,
  output logic sel_done_o,
  output logic sel_fail_o
);
  logic [4:0] tcnt;
  logic [4:0] scnt;
  logic sbusy;
  // Answers after dly_i cycles; data toggles while not valid
  always_ff @(posedge core_clk_i) begin
    table_ack_o <= 1'b0;
    sel_done_o <= 1'b0;
    sel_fail_o <= 1'b0;
    table_data_o <= ~table_data_o;
    if (reset_i) begin
      tcnt <= 5'h00;
      scnt <= 5'h00;
      sbusy <= 1'b0;
    end else begin
      if (table_req_i && !table_ack_o) begin
        tcnt <= tcnt + 5'h01;
        if (tcnt == dly_i) begin
          table_ack_o <= 1'b1;
          table_data_o <= {8'h00, table_addr_i[23:0]};
          tcnt <= 5'h00;
        end
      end
      if (select_i) begin
        sbusy <= 1'b1;
        scnt <= 5'h00;
      end else if (sbusy) begin
        scnt <= scnt + 5'h01;
        if (scnt == dly_i) begin
          sbusy <= 1'b0;
          sel_fail_o <= fail_i;
          sel_done_o <= !fail_i;
        end
      end
    end
  end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module testbench;
  // ===========================================================
  // Clock, reset and wiring
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, table_addr, table_data, next_ip, next_addr, r;
  logic [31:0] rng = 32'h13E1;
  logic pready, pslverr, table_req, table_ack, sel_done, sel_fail, sel_start;
  logic tgt, illegal, ack_out, atn_out, err, lb = 1'b0;
  logic [2:0] dest_id;
  logic [7:0] sync_xfer, cfg_bits;
  int fail_count = 0, checks = 0, cycles = 0;
  always #10 core_clk_i = ~core_clk_i;
  io_regop_decoder dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .table_req_o(table_req),
    .table_addr_o(table_addr), .table_ack_i(table_ack), .table_data_i(table_data),
    .sel_done_i(sel_done), .sel_fail_i(sel_fail), .select_start_o(sel_start),
    .dest_id_o(dest_id), .sync_xfer_o(sync_xfer), .config_bits_o(cfg_bits),
    .next_ip_o(next_ip), .next_address_o(next_addr), .target_role_o(tgt),
    .illegal_o(illegal), .acknowledge_out_o(ack_out), .attention_out_o(atn_out));
  scsi_side_model far (.core_clk_i(core_clk_i), .reset_i(reset_i), .table_req_i(table_req),
    .table_addr_i(table_addr), .select_i(sel_start), .fail_i(1'b1), .dly_i(5'h0C),
    .table_ack_o(table_ack), .table_data_o(table_data), .sel_done_o(sel_done),
    .sel_fail_o(sel_fail));
  // ===========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [31:0] sext(input logic [23:0] x);
    return {{8{x[23]}}, x};
  endfunction
  // Byte operator result with carry on top; shifts run through carry
  function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a, i,
                                     input logic c);
    case (op)
      3'h0: return {c, i};
      3'h1: return {a, c};
      3'h2: return {c, a | i};
      3'h3: return {c, a ^ i};
      3'h4: return {c, a & i};
      3'h5: return {a[0], c, a[7:1]};
      3'h6: return {1'b0, a} + {1'b0, i};
      default: return {1'b0, a} + {1'b0, i} + {8'h00, c};
    endcase
  endfunction
  task chk(input logic [31:0] seen, exp, input string name);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; request stands until ready, answer taken at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1) @(posedge core_clk_i);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task exec(input logic [31:0] f, s);
    apb(1'b1, 12'h000, f);
    apb(1'b1, 12'h004, s);
    apb(1'b1, 12'h008, {30'h0, lb, 1'b1});
    r = 32'h1;
    for (int k = 0; k < 40 && r[0] !== 1'b0; k++) apb(1'b0, 12'h00C, 32'h0);
  endtask
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ===========================================================
  // Main sequence
  initial begin
    logic [31:0] f, s, ip, base, e, v, cmp;
    logic [8:0] x;
    logic [31:0] io_f [4] = '{32'h1800_0048, 32'h1800_0200, 32'h2000_0000, 32'h2000_0240};
    logic [5:0] io_e [4] = '{6'h1E, 6'h27, 6'h3F, 6'h0C};
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    apb(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0, "status reset");
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1, "unmapped error");
    for (int o = 5; o < 8; o++) begin
      for (int p = 0; p < 8; p++) begin
        v = rnd();
        cmp = rnd();
        e = rnd();
        s = rnd();
        exec(e[16] ? 32'h1800_0400 : 32'h2000_0400, 32'h0);
        apb(1'b1, 12'h200 + {e[6:0], 2'b00}, {24'h0, v[7:0]});
        apb(1'b1, 12'h018, {24'h0, cmp[7:0]});
        exec({2'b01, o[2:0], p[2:0], 1'b0, e[6:0], e[15:8], 8'h00}, s);
        x = alu(p[2:0], o == 5 ? cmp[7:0] : v[7:0], e[15:8], e[16]);
        apb(1'b0, 12'h018, 32'h0);
        chk(r[7:0], o == 6 ? x[7:0] : cmp[7:0], "compare");
        apb(1'b0, 12'h200 + {e[6:0], 2'b00}, 32'h0);
        chk(r[7:0], o == 6 ? v[7:0] : x[7:0], "register");
        apb(1'b0, 12'h00C, 32'h0);
        chk(r[2], x[8], "carry");
        apb(1'b0, 12'h020, 32'h0);
        chk(r, s, "next address");
      end
    end
    $display("test read write done");
    for (int k = 0; k < 4; k++) begin
      lb = (k == 2);
      e = rnd();
      exec(io_f[k] | e[2:0], 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk({tgt, ack_out, atn_out, r[5:3]}, io_e[k], "io controls");
    end
    exec(32'h2000_0008, 32'h0);
    exec(32'h1900_0000, 32'h0);
    chk(illegal, 1'b1, "illegal");
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b0, 12'h00C, 32'h0);
    chk({illegal, r[1]}, 2'b00, "illegal clear");
    $display("test set clear done");
    for (int m = 0; m < 4; m++) begin
      ip = rnd() & 32'hFFFF_FFFC;
      base = rnd() & 32'hFFFF_FFFC;
      f = rnd();
      s = rnd();
      f = {5'h00, m[1], m[0], 1'b1, m[0] ? f[23:0] : {5'h00, f[18:16], 16'h0}};
      apb(1'b1, 12'h014, ip);
      apb(1'b1, 12'h010, base);
      exec(f, s);
      chk(atn_out, 1'b1, "select attention");
      e = base + sext(f[23:0]);
      if (m[0]) begin
        chk(table_addr, e, "table address");
        chk({cfg_bits, sync_xfer, dest_id}, {e[7:0], e[23:16], e[10:8]}, "table");
      end else begin
        chk(dest_id, f[18:16], "dest id");
      end
      for (int k = 0; k < 60 && sel_fail !== 1'b1; k++) begin
        @(posedge core_clk_i);
        #1;
      end
      @(posedge core_clk_i);
      #1;
      chk(next_ip, m[1] ? ip + sext(s[23:0]) : s, "fail address");
      chk({illegal, atn_out}, 2'b00, "after select");
    end
    $display("test selection done");
    end_sim();
  end
endmodule
